/* File: rtl/gbf_top.sv */
// module: block fill/copy engine with register port and memory master
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gbf_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output gbf_pkg::gbf_mem_t mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic irq
);
  import gbf_pkg::*;

  // ==========================================================
  // registers
  logic [4:0] src_pix_r;
  logic [4:0] first_pixel_bit_r;
  logic [4:0] last_pixel_bit_r;
  logic [31:0] src_base_r;
  logic [31:0] target_base_addr_r;
  logic [11:0] source_words_per_row_r;
  logic [11:0] source_row_stride_r;
  logic [11:0] target_words_per_row_r;
  logic [10:0] target_row_count_r;
  logic [11:0] target_row_stride_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [31:0] key_r;
  logic [31:0] fore_colour_value_r;
  logic irq_r;
  logic [31:0] rdata_r;
  gbf_mem_t mem_r;
  gbf_state_t st_r;
  logic [11:0] x_r;
  logic [10:0] y_r;
  logic [31:0] src_word_r;

  logic wr_ctrl;
  logic start;
  logic abort;
  logic fill_on;
  logic x_last;
  logic y_last;
  logic done;
  logic [11:0] src_step;
  logic [31:0] src_addr;
  logic [31:0] tgt_addr;
  logic [31:0] lane;
  logic [31:0] res;
  logic [5:0] bpp;
  logic [6:0] end_bit;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign start = wr_ctrl && reg_wdata[B_EN] && (st_r == ST_IDLE); // [RULE20]
  assign abort = wr_ctrl && !reg_wdata[B_EN] && (st_r != ST_IDLE);
  assign fill_on = ctrl_r[B_FILL];
  assign x_last = (x_r == target_words_per_row_r); // [RULE2]
  assign y_last = (y_r == target_row_count_r); // [RULE3]
  assign done = (st_r == ST_NXT) && x_last && y_last;
  assign bpp = gbf_bpp(ctrl_r[B_DEPTH +: 3]); // [RULE11]

  // ==========================================================
  // register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_pix_r <= 5'h00;
      first_pixel_bit_r <= 5'h00;
      last_pixel_bit_r <= 5'h00;
      src_base_r <= WORD_RST;
      target_base_addr_r <= WORD_RST;
      source_words_per_row_r <= 12'h000;
      source_row_stride_r <= 12'h000;
      target_words_per_row_r <= 12'h000;
      target_row_count_r <= 11'h000;
      target_row_stride_r <= 12'h000;
      key_r <= WORD_RST;
      fore_colour_value_r <= WORD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_SRC_PIX: src_pix_r <= reg_wdata[4:0];
        OFS_TGT_PIX: begin
          first_pixel_bit_r <= reg_wdata[4:0]; // [RULE19]
          last_pixel_bit_r <= reg_wdata[20:16]; // [RULE19]
        end
        OFS_SRC_BASE: src_base_r <= {reg_wdata[31:2], 2'b00};
        OFS_TGT_BASE: target_base_addr_r <= {reg_wdata[31:2], 2'b00};
        OFS_SRC_WPR: source_words_per_row_r <= reg_wdata[11:0];
        OFS_SRC_STRIDE: source_row_stride_r <= reg_wdata[11:0];
        OFS_TGT_WPR: target_words_per_row_r <= reg_wdata[11:0];
        OFS_TGT_ROWS: target_row_count_r <= reg_wdata[10:0];
        OFS_TGT_STRIDE: target_row_stride_r <= reg_wdata[11:0];
        OFS_KEY: key_r <= reg_wdata;
        OFS_FORE: fore_colour_value_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // control word; hardware clears enable when the walk ends
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
    end else if (done) begin
      ctrl_r[B_EN] <= 1'b0; // [RULE6]
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // interrupt
  // set wins over the clearing control write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else if (done && ctrl_r[B_IRQ_ON]) begin
      irq_r <= 1'b1; // [RULE7] [RULE22]
    end else if (wr_ctrl) begin
      irq_r <= 1'b0; // [RULE22]
    end
  end

  // ==========================================================
  // read answer, zero outside its one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= WORD_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_SRC_PIX: rdata_r <= {27'h0, src_pix_r};
        OFS_TGT_PIX: rdata_r <= {11'h0, last_pixel_bit_r, 11'h0, first_pixel_bit_r};
        OFS_SRC_BASE: rdata_r <= src_base_r;
        OFS_TGT_BASE: rdata_r <= target_base_addr_r;
        OFS_SRC_WPR: rdata_r <= {20'h0, source_words_per_row_r};
        OFS_SRC_STRIDE: rdata_r <= {20'h0, source_row_stride_r};
        OFS_TGT_WPR: rdata_r <= {20'h0, target_words_per_row_r};
        OFS_TGT_ROWS: rdata_r <= {21'h0, target_row_count_r};
        OFS_TGT_STRIDE: rdata_r <= {20'h0, target_row_stride_r};
        OFS_CTRL: rdata_r <= {15'h0, ctrl_r};
        OFS_KEY: rdata_r <= key_r;
        OFS_FORE: rdata_r <= fore_colour_value_r;
        default: rdata_r <= WORD_RST;
      endcase
    end else begin
      rdata_r <= WORD_RST;
    end
  end

  // ==========================================================
  // walk addresses; packed source rows follow each other
  assign src_step = ctrl_r[B_SAME] ? (source_words_per_row_r + 12'h001) // [RULE10] [RULE18]
                                   : source_row_stride_r; // [RULE1]

  gbf_walk u_src_walk (
    .base(src_base_r),
    .stride(src_step),
    .x(x_r),
    .y(y_r),
    .hway(ctrl_r[B_SH]),
    .vway(ctrl_r[B_SV]),
    .addr(src_addr)
  );

  gbf_walk u_tgt_walk (
    .base(target_base_addr_r),
    .stride(target_row_stride_r), // [RULE1]
    .x(x_r),
    .y(y_r),
    .hway(ctrl_r[B_TH]), // [RULE15]
    .vway(ctrl_r[B_TV]),
    .addr(tgt_addr)
  );

  // ==========================================================
  // lane mask
  // edge words keep the bits outside the first and last pixel
  always_comb begin
    end_bit = {2'b00, last_pixel_bit_r} + {1'b0, bpp};
    lane = 32'hFFFF_FFFF;
    if (x_r == 12'h000) begin
      lane = lane & (32'hFFFF_FFFF << first_pixel_bit_r); // [RULE19]
    end
    if (x_last && end_bit < 7'h20) begin
      lane = lane & ~(32'hFFFF_FFFF << end_bit[4:0]); // [RULE19]
    end
  end

  // ==========================================================
  // pixel combine
  gbf_pix u_pix (
    .src(src_word_r),
    .old(mem_rdata),
    .fore(fore_colour_value_r),
    .key(key_r),
    .lane(lane),
    .depth(ctrl_r[B_DEPTH +: 3]),
    .msel(ctrl_r[B_MSEL +: 2]),
    .tsel(ctrl_r[B_TSEL +: 2]),
    .key_on(ctrl_r[B_KEY]),
    .fill(fill_on),
    .res(res)
  );

  // ==========================================================
  // sequencer: read source (copy only), read target, write back, step
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
    end else if (abort) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: if (start) st_r <= ST_ISS;
        ST_ISS: st_r <= fill_on ? ST_RDT : ST_RDS; // [RULE21]
        ST_RDS: if (mem_ack) st_r <= ST_RDT;
        ST_RDT: if (mem_ack) st_r <= ST_WR;
        ST_WR: if (mem_ack) st_r <= ST_NXT;
        ST_NXT: st_r <= done ? ST_IDLE : ST_ISS;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // word and line counters
  always_ff @(posedge core_clk) begin
    if (reset) begin
      x_r <= 12'h000;
      y_r <= 11'h000;
    end else if (start) begin
      x_r <= 12'h000;
      y_r <= 11'h000;
    end else if (st_r == ST_NXT && !done) begin
      if (x_last) begin
        x_r <= 12'h000;
        y_r <= y_r + 11'h001; // [RULE3]
      end else begin
        x_r <= x_r + 12'h001; // [RULE2]
      end
    end
  end

  // source word waits here for the target read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_word_r <= WORD_RST;
    end else if (st_r == ST_RDS && mem_ack) begin
      src_word_r <= mem_rdata;
    end
  end

  // ==========================================================
  // memory request
  // a request stands until its acknowledge or an abort
  always_ff @(posedge core_clk) begin
    if (reset || abort) begin
      mem_r <= '0;
    end else begin
      case (st_r)
        ST_ISS: begin
          mem_r.req <= 1'b1;
          mem_r.we <= 1'b0;
          mem_r.addr <= fill_on ? tgt_addr : src_addr;
        end
        ST_RDS: if (mem_ack) mem_r.addr <= tgt_addr;
        ST_RDT: if (mem_ack) begin
          mem_r.we <= 1'b1;
          mem_r.data <= res; // [RULE12] [RULE13] [RULE14]
        end
        ST_WR: if (mem_ack) begin
          mem_r.req <= 1'b0;
          mem_r.we <= 1'b0;
        end
        default: mem_r.req <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = rdata_r;
  assign mem_out = mem_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_done_clears_en: assert property (done |=> !ctrl_r[B_EN]) // [RULE6]
    else $error("enable not cleared at completion");
  chk_irq_on_done: assert property ((done && ctrl_r[B_IRQ_ON]) |=> irq && !ctrl_r[B_EN]) // [RULE22]
    else $error("interrupt not raised with enable clear");
  chk_no_irq_off: assert property ((done && !ctrl_r[B_IRQ_ON] && !irq) |=> !irq) // [RULE7]
    else $error("interrupt raised while disabled");
  chk_irq_holds: assert property ((irq && !wr_ctrl) |=> irq) // [RULE22]
    else $error("interrupt dropped without control write");
  chk_x_bound: assert property (st_r != ST_IDLE |-> x_r <= target_words_per_row_r) // [RULE2]
    else $error("word counter beyond row width");
  chk_row_step: assert property ((st_r == ST_NXT && x_last && !y_last && !abort)
    |=> x_r == 12'h000 && y_r == $past(y_r) + 11'h001) // [RULE3]
    else $error("row step wrong");
  chk_fill_no_src: assert property ((fill_on && st_r == ST_ISS && !abort) |=> st_r == ST_RDT) // [RULE21]
    else $error("fill read the source");
  chk_write_addr: assert property ((st_r == ST_WR && mem_r.req) |-> mem_r.we && mem_r.addr == tgt_addr) // [RULE15]
    else $error("write not at target walk address");
  chk_rd_one_cycle: assert property ((!reg_rd) |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  // walk, handshake, lane and interrupt
  chk_start_walk: assert property (start |=> st_r == ST_ISS && x_r == 12'h000 && y_r == 11'h000) // [RULE20]
    else $error("start did not reset the walk");
  chk_done_idle: assert property (done |=> st_r == ST_IDLE) // [RULE6]
    else $error("engine busy after completion");
  chk_abort_idle: assert property (abort |=> st_r == ST_IDLE && !mem_out.req)
    else $error("abort left the engine running");
  chk_y_bound: assert property (st_r != ST_IDLE |-> y_r <= target_row_count_r) // [RULE3]
    else $error("line counter beyond row count");
  chk_word_step: assert property ((st_r == ST_NXT && !x_last && !abort) // [RULE2]
    |=> x_r == $past(x_r) + 12'h001 && y_r == $past(y_r))
    else $error("word step wrong");
  chk_copy_src_first: assert property ((!fill_on && st_r == ST_ISS && !abort) // [RULE15]
    |=> st_r == ST_RDS && mem_out.addr == $past(src_addr))
    else $error("copy did not read the source first");
  chk_req_holds: assert property ((mem_out.req && !mem_ack && !abort)
    |=> mem_out.req && $stable(mem_out.addr) && $stable(mem_out.we) && $stable(mem_out.data))
    else $error("memory request changed before acknowledge");
  chk_keep_lane: assert property ((st_r == ST_RDT && mem_ack && !abort) // [RULE19]
    |=> ((mem_out.data ^ $past(mem_rdata)) & ~$past(lane)) == 32'h0000_0000)
    else $error("bits outside the lane changed");
  chk_irq_only_done: assert property ((!irq && !(done && ctrl_r[B_IRQ_ON])) // [RULE7]
    |=> !irq)
    else $error("interrupt raised without completion");

  cov_fill_done: cover property (done && fill_on);
  cov_copy_done: cover property (done && !fill_on);
  cov_key_copy: cover property (st_r == ST_WR && ctrl_r[B_KEY]);
  cov_abort_run: cover property (abort);
  cov_reverse_walk: cover property (st_r == ST_WR && ctrl_r[B_TH]);
endmodule
`default_nettype wire

/* File: rtl/gbf_pkg.sv */
// package: constants, types and helpers for the block fill/copy engine
// How it works
// RULE1: row stride counts words per display row
// RULE2: target words per row is count minus one
// RULE3: target row count is lines minus one
// RULE4: software loads word-aligned target base address
// RULE5: fill with mask 0x1 ANDs; depth 0x4 16-bit
// RULE6: enable bit clears when the operation finishes
// RULE7: interrupt on completion only when enabled
// RULE8: software zeroes control before a new setup
// RULE9: software keeps interrupt acknowledge flag zero
// RULE10: same-size flag packs source rows into words
// RULE11: depth code sets bits per pixel
// RULE12: mask selector picks AND, OR or XOR
// RULE13: target selector combines with existing target pixels
// RULE14: key colour skips matching pixels, else copy
// RULE15: way bits set X and Y directions
// RULE16: software reverses directions for forward overlap
// RULE17: software keeps source and target ways equal
// RULE18: source words per row is count minus one
// RULE19: pixel bit fields are x times depth mod 32
// RULE20: setting enable starts processing last
// RULE21: fill writes the foreground colour value
// RULE22: enable clears with interrupt; interrupt holds until control write
package gbf_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SRC_PIX = 8'h00;
  localparam logic [7:0] OFS_TGT_PIX = 8'h04;
  localparam logic [7:0] OFS_SRC_BASE = 8'h08;
  localparam logic [7:0] OFS_TGT_BASE = 8'h0C;
  localparam logic [7:0] OFS_SRC_WPR = 8'h10;
  localparam logic [7:0] OFS_SRC_STRIDE = 8'h14;
  localparam logic [7:0] OFS_TGT_WPR = 8'h18;
  localparam logic [7:0] OFS_TGT_ROWS = 8'h1C;
  localparam logic [7:0] OFS_TGT_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_KEY = 8'h28;
  localparam logic [7:0] OFS_FORE = 8'h2C;
  // ==========================================================
  // control field positions
  localparam int B_EN = 0;
  localparam int B_FILL = 1;
  localparam int B_IRQ_ON = 2;
  localparam int B_ACK = 3;
  localparam int B_MSEL = 4;
  localparam int B_TSEL = 6;
  localparam int B_DEPTH = 8;
  localparam int B_KEY = 11;
  localparam int B_SAME = 12;
  localparam int B_SH = 13;
  localparam int B_SV = 14;
  localparam int B_TH = 15;
  localparam int B_TV = 16;
  localparam int CTRL_W = 17;
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h0_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // ==========================================================
  // encodings
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_AND = 2'h1;
  localparam logic [1:0] OP_OR = 2'h2;
  localparam logic [1:0] OP_XOR = 2'h3;
  localparam logic [2:0] DEP_8 = 3'h3;
  localparam logic [2:0] DEP_16 = 3'h4;
  localparam logic [2:0] DEP_32 = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISS = 3'b001,
    ST_RDS = 3'b011,
    ST_RDT = 3'b010,
    ST_WR = 3'b110,
    ST_NXT = 3'b111
  } gbf_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } gbf_mem_t;

  function automatic logic [5:0] gbf_bpp(input logic [2:0] code);
    case (code)
      DEP_16: gbf_bpp = 6'h10;
      DEP_32: gbf_bpp = 6'h20;
      default: gbf_bpp = 6'h08;
    endcase
  endfunction

  // copies the low pixel of v into every pixel slot of the word
  function automatic logic [31:0] gbf_rep(input logic [31:0] v, input logic [5:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[i % int'(w)];
    end
    return r;
  endfunction
endpackage

/* File: rtl/gbf_walk.sv */
// module: word address of one walk position in a frame buffer
`timescale 1ns/1ps
`default_nettype none
module gbf_walk (
  input wire logic [31:0] base,
  input wire logic [11:0] stride,
  input wire logic [11:0] x,
  input wire logic [10:0] y,
  input wire logic hway,
  input wire logic vway,
  output logic [31:0] addr
);
  logic [31:0] xo;
  logic [31:0] yo;
  logic [22:0] row_off;
  always_comb begin
    xo = {18'h0, x, 2'b00};
    // full-width product; a 12-bit one would wrap on tall frames
    row_off = 23'(stride) * 23'(y);
    yo = {7'h00, row_off, 2'b00};
    // reverse ways walk down from the base word
    addr = base + (hway ? -xo : xo) + (vway ? -yo : yo); // [RULE15]
  end
endmodule
`default_nettype wire

/* File: rtl/gbf_pix.sv */
// module: per-word pixel combine with mask, target logic and key colour
`timescale 1ns/1ps
`default_nettype none
module gbf_pix (
  input wire logic [31:0] src,
  input wire logic [31:0] old,
  input wire logic [31:0] fore,
  input wire logic [31:0] key,
  input wire logic [31:0] lane,
  input wire logic [2:0] depth,
  input wire logic [1:0] msel,
  input wire logic [1:0] tsel,
  input wire logic key_on,
  input wire logic fill,
  output logic [31:0] res
);
  import gbf_pkg::*;
  logic [5:0] w;
  logic [31:0] fr;
  logic [31:0] base;
  logic [31:0] mk;
  logic [31:0] tg;
  logic [31:0] keep;
  logic [31:0] wr;

  function automatic logic [31:0] pix_eq(input logic [31:0] x, input logic [5:0] w);
    logic [31:0] m;
    logic [31:0] g;
    logic [31:0] wm;
    m = 32'h0000_0000;
    wm = (w == 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << w) - 32'h0000_0001);
    for (int i = 0; i < 32; i++) begin
      g = (x >> ((i / int'(w)) * int'(w))) & wm;
      m[i] = (g == wm);
    end
    return m;
  endfunction

  always_comb begin
    w = gbf_bpp(depth); // [RULE11]
    fr = gbf_rep(fore, w); // [RULE21]
    base = fill ? old : src;
    case (msel) // [RULE12] [RULE5]
      OP_AND: mk = base & fr;
      OP_OR: mk = base | fr;
      OP_XOR: mk = base ^ fr;
      default: mk = fill ? fr : src;
    endcase
    case (tsel) // [RULE13]
      OP_AND: tg = mk & old;
      OP_OR: tg = mk | old;
      OP_XOR: tg = mk ^ old;
      default: tg = mk;
    endcase
    // matching source pixels leave the target untouched
    keep = (key_on && !fill) ? pix_eq(~(src ^ gbf_rep(key, w)), w) : 32'h0000_0000; // [RULE14]
    wr = lane & ~keep;
    res = (wr & tg) | (~wr & old);
  end
endmodule
`default_nettype wire

/* File: sim/gbf_mem_model.sv */
// memory model: word frame buffer behind the engine's memory master
`timescale 1ns/1ps
`default_nettype none
module gbf_mem_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire gbf_pkg::gbf_mem_t mem_out,
  input wire logic [3:0] slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  import gbf_pkg::*;
  logic [31:0] mem [0:255];
  logic [3:0] wait_r;
  // ==========================================================
  // answer
  // one ack pulse per request after slow idle cycles; the data bus
  // toggles whenever no read answer stands so stale data never matches
  always @(posedge core_clk) begin
    if (reset) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_ack || !mem_out.req) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_r >= slow) begin
      mem_ack <= 1'b1;
      if (mem_out.we) begin
        mem[mem_out.addr[9:2]] <= mem_out.data;
        mem_rdata <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_out.addr[9:2]];
      end
    end else begin
      wait_r <= wait_r + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// testbench: register-driven fill and copy runs against a memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gbf_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  gbf_mem_t mem_out;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic irq;
  logic [3:0] slow = 4'h0;
  logic [31:0] v;
  logic [31:0] c;
  int failures = 0;
  int n_tests = 0;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  gbf_top gbf_top_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
  gbf_mem_model gbf_mem_model_inst (.core_clk(core_clk), .reset(reset),
    .mem_out(mem_out), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================================
  // register port tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // answer stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tgt(input logic [31:0] b, w, h, s, p);
    wr(OFS_TGT_BASE, b);
    wr(OFS_TGT_WPR, w);
    wr(OFS_TGT_ROWS, h);
    wr(OFS_TGT_STRIDE, s);
    wr(OFS_TGT_PIX, p);
  endtask

  // clear, configure, then enable last; poll enable under a bound
  task automatic go(input logic [31:0] cw);
    int i;
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, cw);
    wr(OFS_CTRL, cw | 32'h0000_0001);
    for (i = 0; i < 300; i++) begin
      rd(OFS_CTRL);
      if (v[B_EN] === 1'b0) break;
    end
    if (i == 300) begin
      failures++;
      wrap_up();
    end
    chk(v, cw);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFS_CTRL);
    chk(v, 32'h0000_0000);
    rd(8'h30);
    chk(v, 32'h0000_0000);
    wr(OFS_TGT_BASE, 32'h0000_0103);
    rd(OFS_TGT_BASE);
    chk(v, 32'h0000_0100);
    $display("test 1 done");
    // 2x2 fill inside a wider frame, AND mask, 16 bpp
    for (int k = 0; k < 24; k++) gbf_mem_model_inst.mem[8'h40 + k] = 32'hFFFF_FF00 | k;
    tgt(32'h0000_0100, 32'h1, 32'h1, 32'h8, 32'h0010_0000);
    wr(OFS_FORE, 32'h0000_1234);
    c = (1 << B_FILL) | (1 << B_IRQ_ON) | (OP_AND << B_MSEL) | (DEP_16 << B_DEPTH);
    go(c);
    chk({31'h0, irq}, 32'h1);
    for (int k = 0; k < 24; k++) begin
      v = 32'hFFFF_FF00 | k;
      if (k % 8 < 2 && k < 16) v = v & 32'h1234_1234;
      chk(gbf_mem_model_inst.mem[8'h40 + k], v);
    end
    wr(OFS_CTRL, 32'h0000_0000);
    #1;
    chk({31'h0, irq}, 32'h0);
    $display("test 2 done");
    // XOR fill, 8 bpp, first pixel at x=1 keeps the low byte
    slow <= 4'h5;
    gbf_mem_model_inst.mem[8'h80] = 32'h1234_5678;
    tgt(32'h0000_0200, 32'h0, 32'h0, 32'h8, 32'h0018_0008);
    wr(OFS_FORE, 32'h0000_005A);
    go((1 << B_FILL) | (OP_XOR << B_MSEL) | (DEP_8 << B_DEPTH));
    chk({31'h0, irq}, 32'h0);
    chk(gbf_mem_model_inst.mem[8'h80], 32'h486E_0C78);
    $display("test 3 done");
    // keyed copy of two packed source rows
    slow <= 4'h0;
    gbf_mem_model_inst.mem[8'hC0] = 32'h2211_3311;
    gbf_mem_model_inst.mem[8'hC1] = 32'h1111_5511;
    gbf_mem_model_inst.mem[8'hD0] = 32'hAAAA_AAAA;
    gbf_mem_model_inst.mem[8'hD8] = 32'hAAAA_AAAA;
    tgt(32'h0000_0340, 32'h0, 32'h1, 32'h8, 32'h0018_0000);
    wr(OFS_SRC_BASE, 32'h0000_0300);
    wr(OFS_SRC_WPR, 32'h0000_0000);
    wr(OFS_SRC_STRIDE, 32'h0000_0010);
    wr(OFS_KEY, 32'h1111_1111);
    go((1 << B_KEY) | (1 << B_SAME) | (DEP_8 << B_DEPTH));
    chk(gbf_mem_model_inst.mem[8'hD0], 32'h22AA_33AA);
    chk(gbf_mem_model_inst.mem[8'hD8], 32'hAAAA_55AA);
    $display("test 4 done");
    // overlapping copy right to left, target XOR, 32 bpp
    slow <= 4'h3;
    gbf_mem_model_inst.mem[8'hE2] = 32'h0000_00A5;
    gbf_mem_model_inst.mem[8'hE3] = 32'h0000_5A00;
    gbf_mem_model_inst.mem[8'hE4] = 32'h0F00_000F;
    tgt(32'h0000_0390, 32'h1, 32'h0, 32'h8, 32'h0000_0000);
    wr(OFS_SRC_BASE, 32'h0000_038C);
    wr(OFS_SRC_WPR, 32'h0000_0001);
    wr(OFS_SRC_STRIDE, 32'h0000_0008);
    c = (1 << B_SH) | (1 << B_SV) | (1 << B_TH) | (1 << B_TV);
    go(c | (OP_XOR << B_TSEL) | (DEP_32 << B_DEPTH));
    chk(gbf_mem_model_inst.mem[8'hE4], 32'h0F00_5A0F);
    chk(gbf_mem_model_inst.mem[8'hE3], 32'h0000_5AA5);
    chk(gbf_mem_model_inst.mem[8'hE2], 32'h0000_00A5);
    $display("test 5 done");
    // abort a slow fill by clearing control mid-run
    slow <= 4'hF;
    tgt(32'h0000_03C0, 32'h3, 32'h3, 32'h4, 32'h0000_0000);
    c = (1 << B_FILL) | (1 << B_IRQ_ON) | (DEP_32 << B_DEPTH);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, c | 32'h0000_0001);
    repeat (10) @(posedge core_clk);
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, mem_out.req}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_CTRL);
    chk(v, 32'h0000_0000);
    $display("test 6 done");
    // copy through the source stride, OR mask, AND target, last pixel lane
    slow <= 4'h1;
    gbf_mem_model_inst.mem[8'hA0] = 32'h1020_3040;
    gbf_mem_model_inst.mem[8'hA1] = 32'h0000_0000;
    gbf_mem_model_inst.mem[8'hA4] = 32'h5060_7080;
    gbf_mem_model_inst.mem[8'hB0] = 32'hFFFF_FFFF;
    gbf_mem_model_inst.mem[8'hB2] = 32'hF0F0_F0F0;
    tgt(32'h0000_02C0, 32'h0, 32'h1, 32'h2, 32'h0008_0008);
    wr(OFS_SRC_BASE, 32'h0000_0280);
    wr(OFS_SRC_STRIDE, 32'h0000_0004);
    wr(OFS_FORE, 32'h0000_000F);
    c = (1 << B_IRQ_ON) | (OP_OR << B_MSEL) | (OP_AND << B_TSEL) | (DEP_8 << B_DEPTH);
    go(c);
    chk({31'h0, irq}, 32'h1);
    chk(gbf_mem_model_inst.mem[8'hB0], 32'hFFFF_3FFF);
    chk(gbf_mem_model_inst.mem[8'hB2], 32'hF0F0_70F0);
    $display("test 7 done");
    wrap_up();
  end
endmodule
`default_nettype wire
